// file: rtl/sscb_pkg.sv
// constants and types of the configuration bank
package sscb_pkg;

  // ****************************************
  // word and hold register layout
  // ****************************************
  localparam int unsigned WORD_W   = 26;
  localparam int unsigned HOLD_W   = 24;
  localparam int unsigned HOLD_LSB = 2;
  localparam logic [HOLD_W-1:0] HOLD_RESET = 24'h000000;

  localparam logic [1:0] ADDR_OPERATION_MODE     = 2'h0;
  localparam logic [1:0] ADDR_AUTO_CALIBRATION   = 2'h1;
  localparam logic [1:0] ADDR_FREQUENCY_ONE      = 2'h2;
  localparam logic [1:0] ADDR_FREQUENCY_TWO      = 2'h3;

  // field positions in load-word bit numbering
  localparam int unsigned PUMP_CUR_LO   = 2;
  localparam int unsigned PUMP_DELAY_LO = 5;
  localparam int unsigned POLARITY_BIT  = 7;
  localparam int unsigned PUMP_HIGHZ_BIT = 8;
  localparam int unsigned MOD_SUPPLY_BIT = 10;
  localparam int unsigned DIV_SUPPLY_BIT = 11;
  localparam int unsigned PLL_SUPPLY_BIT = 12;
  localparam int unsigned REF_BW_LO     = 13;
  localparam int unsigned DIAG_SEL_LO   = 15;
  localparam int unsigned PRE_BIAS_LO   = 21;
  localparam int unsigned PRE_RATIO_BIT = 23;
  localparam int unsigned AUTOTUNE_EN_BIT = 20;

  // fixed by design
  localparam logic [1:0] PUMP_DELAY_FIXED = 2'h0;
  localparam logic       POLARITY_FIXED   = 1'b0;
  localparam logic [10:0] PUMP_STEP_UA    = 11'h0c8;

  // lock pin source codes
  localparam logic [2:0] DIAG_LOCK     = 3'h0;
  localparam logic [2:0] DIAG_REF_DIV  = 3'h1;
  localparam logic [2:0] DIAG_FB_DIV   = 3'h2;
  localparam logic [2:0] DIAG_DLOOP    = 3'h7;

  // ****************************************
  // coarse search timing
  // ****************************************
  localparam int unsigned CAP_W          = 7;
  localparam int unsigned MCLK_PERIOD_NS = 50;
  localparam int unsigned SAR_STEP_NS    = 1000;
  localparam int unsigned SAR_STEP_CYC   = (SAR_STEP_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int unsigned SAR_CNT_W      = 8;
  localparam logic [SAR_CNT_W-1:0] SAR_CNT_LAST = 8'(SAR_STEP_CYC - 1);

  typedef enum logic [1:0] {
    SSCB_SAR_IDLE,
    SSCB_SAR_SETTLE
  } sscb_sar_state_t;

  typedef enum logic [1:0] {
    SSCB_TUNE_WAIT,
    SSCB_TUNE_SEARCH,
    SSCB_TUNE_FINE
  } sscb_tune_state_t;

endpackage : sscb_pkg

// file: rtl/sscb_link_shift.sv
// serial load register clocked by the host's serial clock
`timescale 1ns/10ps
module sscb_link_shift
  import sscb_pkg::*;
(
  input  wire logic              sclk,
  input  wire logic              latch_strobe,
  input  wire logic              sdata,
  output logic [sscb_pkg::WORD_W-1:0] load_q
);

  // ****************************************
  // shift path
  // ****************************************
  // no reset: link clock may stop at reset
  // R18 shift while strobe low
  always_ff @(posedge sclk) begin
    if (!latch_strobe) begin
      // R17 msb arrives first
      load_q <= {load_q[WORD_W-2:0], sdata};
    end
  end

endmodule : sscb_link_shift

// file: rtl/sscb_coarse_sar.sv
// seven step successive approximation for the coarse capacitor code
`timescale 1ns/10ps
module sscb_coarse_sar
  import sscb_pkg::*;
(
  input  wire logic                    mclk,
  input  wire logic                    rstn,
  input  wire logic                    start,
  input  wire logic                    vco_above,
  output logic [sscb_pkg::CAP_W-1:0]   cap_q,
  output logic                         busy_q,
  output logic                         done_q
);

  sscb_sar_state_t         state_q;
  logic [2:0]              idx_q;
  logic [SAR_CNT_W-1:0]    cnt_q;

  function automatic logic [CAP_W-1:0] trial_bit(input logic [2:0] idx);
    trial_bit = 7'h01 << idx;
  endfunction : trial_bit

  // ****************************************
  // search sequencer
  // ****************************************
  // R1 one bit per step, msb down
  always_ff @(posedge mclk) begin
    done_q <= 1'b0;
    if (!rstn) begin
      state_q <= SSCB_SAR_IDLE;
      idx_q   <= 3'h6;
      cnt_q   <= '0;
      cap_q   <= 7'h40;
      busy_q  <= 1'b0;
    end else if (start) begin
      // restart mid-search
      state_q <= SSCB_SAR_SETTLE;
      idx_q   <= 3'h6;
      cnt_q   <= '0;
      cap_q   <= trial_bit(3'h6);
      busy_q  <= 1'b1;
    end else begin
      unique case (state_q)
        SSCB_SAR_IDLE: begin
          busy_q <= 1'b0;
        end
        SSCB_SAR_SETTLE: begin
          if (cnt_q != SAR_CNT_LAST) begin
            cnt_q <= cnt_q + 8'h01;
          end else begin
            cnt_q <= '0;
            // above target: keep capacitance, it lowers frequency
            if (!vco_above) begin
              cap_q[idx_q] <= 1'b0;
            end
            if (idx_q == 3'h0) begin
              state_q <= SSCB_SAR_IDLE;
              busy_q  <= 1'b0;
              done_q  <= 1'b1;
            end else begin
              idx_q            <= idx_q - 3'h1;
              cap_q[idx_q - 3'h1] <= 1'b1;
            end
          end
        end
        default: begin
          state_q <= SSCB_SAR_IDLE;
        end
      endcase
    end
  end

endmodule : sscb_coarse_sar

// file: rtl/sscb_top.sv
// serially programmed configuration bank of the fractional-n synthesizer
`timescale 1ns/10ps

// Contract
// R1 - auto-tune finds a 7-bit coarse capacitor code in seven approximation steps
// R2 - after the coarse search, fine analog tuning takes over the loop
// R3 - auto-tune is needed after power-on and after a frequency change
// R4 - host writes enable bit 20 as zero then one; rising edge starts tuning
// R5 - address bits 00, 01, 10, 11 pick the four hold registers
// R6 - host sends operation-mode words with address bits zero
// R7 - bits 4:2 give pump current, 200 uA per step from 200 uA
// R8 - pump delay field is ignored; delay stays at 2 ns
// R9 - polarity bit is ignored; detector stays negative
// R10 - bit 8 set puts the charge pump output in high impedance
// R11 - host writes the three supply bits 10 to 12 together
// R12 - bits 14:13 select reference buffer bandwidth 20 to 50 MHz
// R13 - bits 17:15 select the source of the lock indicator pin
// R14 - bits 22:21 select prescaler bias current 20 to 26 uA
// R15 - bit 23 selects prescaler divide 8/9 or 16/17
// R16 - each word is 26 bits; four words configure everything
// R17 - host holds strobe low while shifting, msb first
// R18 - data shifts in on serial clock rising edges while strobe low
// R19 - strobe falling edge copies the load word into the addressed hold register
// R20 - reserved operation-mode bits are written zero and ignored
// R21 - all hold registers clear to zero at power-on reset
module sscb_top
  import sscb_pkg::*;
(
  input  wire logic                     mclk,
  input  wire logic                     rstn,
  input  wire logic                     sclk,
  input  wire logic                     sdata,
  input  wire logic                     latch_strobe,
  input  wire logic                     lock_detect_in,
  input  wire logic                     ref_div_in,
  input  wire logic                     fb_div_in,
  input  wire logic                     dloop_test_in,
  input  wire logic                     vco_above_target,
  output logic [sscb_pkg::HOLD_W-1:0]   operation_mode,
  output logic [sscb_pkg::HOLD_W-1:0]   auto_calibration_control,
  output logic [sscb_pkg::HOLD_W-1:0]   frequency_control_one,
  output logic [sscb_pkg::HOLD_W-1:0]   frequency_control_two,
  output logic [2:0]                    pump_current_sel,
  output logic [10:0]                   pump_current_ua,
  output logic [1:0]                    pump_delay_sel,
  output logic                          detector_polarity,
  output logic                          pump_high_z,
  output logic                          modulator_supply_ctrl,
  output logic                          divider_supply_ctrl,
  output logic                          pll_supply_ctrl,
  output logic [1:0]                    ref_buffer_bandwidth,
  output logic [1:0]                    prescaler_bias_sel,
  output logic                          prescaler_ratio_sel,
  output logic                          lock_indicator_pin,
  output logic                          diag_code_unused,
  output logic [sscb_pkg::CAP_W-1:0]    coarse_cap,
  output logic                          fine_tune_en,
  output logic                          tune_busy,
  output logic                          retune_needed
);

  // ****************************************
  // declarations
  // ****************************************
  logic [WORD_W-1:0]   link_load;
  logic [WORD_W-1:0]   staging_q;
  logic [5:0]          pin_meta_q;
  logic [5:0]          pin_sync_q;
  logic                strobe_dly_q;
  logic                strobe_fall;
  logic [HOLD_W-1:0]   op_q;
  logic [HOLD_W-1:0]   cal_q;
  logic [HOLD_W-1:0]   frq1_q;
  logic [HOLD_W-1:0]   frq2_q;
  logic                at_en_prev_q;
  logic                at_start_q;
  logic                freq_changed;
  logic                retune_q;
  logic                fine_q;
  logic                lock_pin_q;
  logic                diag_unused_q;
  logic [CAP_W-1:0]    sar_cap;
  logic                sar_busy;
  logic                sar_done;
  sscb_tune_state_t    tune_state_q;

  // ****************************************
  // helpers
  // ****************************************
  // hold registers drop the two address bits of the word
  function automatic logic hold_bit(input logic [HOLD_W-1:0] r, input int unsigned pos);
    hold_bit = r[pos - HOLD_LSB];
  endfunction : hold_bit

  function automatic logic [1:0] hold_pair(input logic [HOLD_W-1:0] r, input int unsigned lo);
    hold_pair = {r[lo + 1 - HOLD_LSB], r[lo - HOLD_LSB]};
  endfunction : hold_pair

  function automatic logic [10:0] pump_ua(input logic [2:0] code);
    pump_ua = PUMP_STEP_UA * ({8'h00, code} + 11'h001);
  endfunction : pump_ua

  // ****************************************
  // link domain
  // ****************************************
  sscb_link_shift u_link (
    .sclk         (sclk),
    .latch_strobe (latch_strobe),
    .sdata        (sdata),
    .load_q       (link_load)
  );

  // ****************************************
  // pin synchronisers
  // ****************************************
  // every pin here is asynchronous to mclk
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pin_meta_q <= 6'h00;
      pin_sync_q <= 6'h00;
    end else begin
      pin_meta_q <= {vco_above_target, dloop_test_in, fb_div_in,
                     ref_div_in, lock_detect_in, latch_strobe};
      pin_sync_q <= pin_meta_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      strobe_dly_q <= 1'b0;
    end else begin
      strobe_dly_q <= pin_sync_q[0];
    end
  end

  // R19 falling edge of the synchronised strobe
  assign strobe_fall = strobe_dly_q && !pin_sync_q[0];

  // ****************************************
  // load word capture
  // ****************************************
  // frozen while strobe high; host waits 3 mclk before shifting
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      staging_q <= '0;
    end else if (pin_sync_q[0] && strobe_dly_q) begin
      // R16 whole 26-bit word taken at once
      staging_q <= link_load;
    end
  end

  // ****************************************
  // hold registers
  // ****************************************
  // R21 cleared at power-on
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      op_q   <= HOLD_RESET;
      cal_q  <= HOLD_RESET;
      frq1_q <= HOLD_RESET;
      frq2_q <= HOLD_RESET;
    end else if (strobe_fall) begin
      // R5 two address bits pick the target
      unique case (staging_q[1:0])
        ADDR_OPERATION_MODE: begin
          op_q <= staging_q[WORD_W-1:HOLD_LSB];
        end
        ADDR_AUTO_CALIBRATION: begin
          cal_q <= staging_q[WORD_W-1:HOLD_LSB];
        end
        ADDR_FREQUENCY_ONE: begin
          frq1_q <= staging_q[WORD_W-1:HOLD_LSB];
        end
        ADDR_FREQUENCY_TWO: begin
          frq2_q <= staging_q[WORD_W-1:HOLD_LSB];
        end
      endcase
    end
  end

  assign operation_mode           = op_q;
  assign auto_calibration_control = cal_q;
  assign frequency_control_one    = frq1_q;
  assign frequency_control_two    = frq2_q;

  // ****************************************
  // operation mode decode
  // ****************************************
  // registered so outputs leave flip-flops
  // R20 reserved bits 9, 20:18 and 25:24 are never read
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pump_current_sel      <= 3'h0;
      pump_current_ua       <= PUMP_STEP_UA;
      pump_delay_sel        <= PUMP_DELAY_FIXED;
      detector_polarity     <= POLARITY_FIXED;
      pump_high_z           <= 1'b0;
      modulator_supply_ctrl <= 1'b0;
      divider_supply_ctrl   <= 1'b0;
      pll_supply_ctrl       <= 1'b0;
      ref_buffer_bandwidth  <= 2'h0;
      prescaler_bias_sel    <= 2'h0;
      prescaler_ratio_sel   <= 1'b0;
    end else begin
      // R7 pump current code and its value in microamps
      pump_current_sel      <= {hold_bit(op_q, PUMP_CUR_LO + 2), hold_pair(op_q, PUMP_CUR_LO)};
      pump_current_ua       <= pump_ua({hold_bit(op_q, PUMP_CUR_LO + 2),
                                        hold_pair(op_q, PUMP_CUR_LO)});
      // R8 delay field ignored
      pump_delay_sel        <= PUMP_DELAY_FIXED;
      // R9 polarity held negative
      detector_polarity     <= POLARITY_FIXED;
      // R10 pump high impedance
      pump_high_z           <= hold_bit(op_q, PUMP_HIGHZ_BIT);
      // R11 supply group follows the word as written
      modulator_supply_ctrl <= hold_bit(op_q, MOD_SUPPLY_BIT);
      divider_supply_ctrl   <= hold_bit(op_q, DIV_SUPPLY_BIT);
      pll_supply_ctrl       <= hold_bit(op_q, PLL_SUPPLY_BIT);
      // R12 reference buffer bandwidth
      ref_buffer_bandwidth  <= hold_pair(op_q, REF_BW_LO);
      // R14 prescaler bias
      prescaler_bias_sel    <= hold_pair(op_q, PRE_BIAS_LO);
      // R15 prescaler ratio
      prescaler_ratio_sel   <= hold_bit(op_q, PRE_RATIO_BIT);
    end
  end

  // ****************************************
  // lock indicator pin
  // ****************************************
  // R13 diagnostic source select; unused codes drive low
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      lock_pin_q    <= 1'b0;
      diag_unused_q <= 1'b0;
    end else begin
      unique case ({hold_bit(op_q, DIAG_SEL_LO + 2), hold_pair(op_q, DIAG_SEL_LO)})
        DIAG_LOCK: begin
          lock_pin_q    <= pin_sync_q[1];
          diag_unused_q <= 1'b0;
        end
        DIAG_REF_DIV: begin
          lock_pin_q    <= pin_sync_q[2];
          diag_unused_q <= 1'b0;
        end
        DIAG_FB_DIV: begin
          lock_pin_q    <= pin_sync_q[3];
          diag_unused_q <= 1'b0;
        end
        DIAG_DLOOP: begin
          lock_pin_q    <= pin_sync_q[4];
          diag_unused_q <= 1'b0;
        end
        default: begin
          lock_pin_q    <= 1'b0;
          diag_unused_q <= 1'b1;
        end
      endcase
    end
  end

  assign lock_indicator_pin = lock_pin_q;
  assign diag_code_unused   = diag_unused_q;

  // ****************************************
  // auto-tune trigger
  // ****************************************
  // R4 start on the enable bit's rising edge only
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      at_en_prev_q <= 1'b0;
      at_start_q   <= 1'b0;
    end else begin
      at_en_prev_q <= hold_bit(cal_q, AUTOTUNE_EN_BIT);
      at_start_q   <= hold_bit(cal_q, AUTOTUNE_EN_BIT) && !at_en_prev_q;
    end
  end

  // unchanged rewrite keeps lock
  assign freq_changed = strobe_fall &&
                        (((staging_q[1:0] == ADDR_FREQUENCY_ONE) &&
                          (staging_q[WORD_W-1:HOLD_LSB] != frq1_q)) ||
                         ((staging_q[1:0] == ADDR_FREQUENCY_TWO) &&
                          (staging_q[WORD_W-1:HOLD_LSB] != frq2_q)));

  // R3 pending after power-on and after a frequency change; set wins
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      retune_q <= 1'b1;
    end else if (freq_changed) begin
      retune_q <= 1'b1;
    end else if (at_start_q) begin
      retune_q <= 1'b0;
    end
  end

  assign retune_needed = retune_q;

  // ****************************************
  // coarse search and fine hand-over
  // ****************************************
  // R1 seven-step search of the capacitor bank
  sscb_coarse_sar u_sar (
    .mclk      (mclk),
    .rstn      (rstn),
    .start     (at_start_q),
    .vco_above (pin_sync_q[5]),
    .cap_q     (sar_cap),
    .busy_q    (sar_busy),
    .done_q    (sar_done)
  );

  // R2 analog fine loop enabled once the code settles
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      tune_state_q <= SSCB_TUNE_WAIT;
      fine_q       <= 1'b0;
    end else if (at_start_q) begin
      tune_state_q <= SSCB_TUNE_SEARCH;
      fine_q       <= 1'b0;
    end else begin
      unique case (tune_state_q)
        SSCB_TUNE_WAIT: begin
          fine_q <= 1'b0;
        end
        SSCB_TUNE_SEARCH: begin
          if (sar_done) begin
            tune_state_q <= SSCB_TUNE_FINE;
            fine_q       <= 1'b1;
          end
        end
        SSCB_TUNE_FINE: begin
          // new frequency: fine off until next search
          if (freq_changed) begin
            tune_state_q <= SSCB_TUNE_WAIT;
            fine_q       <= 1'b0;
          end
        end
        default: begin
          tune_state_q <= SSCB_TUNE_WAIT;
          fine_q       <= 1'b0;
        end
      endcase
    end
  end

  assign fine_tune_en = fine_q;
  assign coarse_cap   = sar_cap;
  assign tune_busy    = sar_busy;

endmodule : sscb_top

// file: tb/sscb_checker.sv
// port assertions of the configuration bank
`timescale 1ns/10ps
module sscb_checker
  import sscb_pkg::*;
(
  input wire logic                          mclk,
  input wire logic                          rstn,
  input wire logic [sscb_pkg::HOLD_W-1:0]   operation_mode,
  input wire logic [sscb_pkg::HOLD_W-1:0]   auto_calibration_control,
  input wire logic [sscb_pkg::HOLD_W-1:0]   frequency_control_one,
  input wire logic [sscb_pkg::HOLD_W-1:0]   frequency_control_two,
  input wire logic [2:0]                    pump_current_sel,
  input wire logic [10:0]                   pump_current_ua,
  input wire logic [1:0]                    pump_delay_sel,
  input wire logic                          detector_polarity,
  input wire logic                          pump_high_z,
  input wire logic                          prescaler_ratio_sel,
  input wire logic                          lock_indicator_pin,
  input wire logic                          diag_code_unused,
  input wire logic [sscb_pkg::CAP_W-1:0]    coarse_cap,
  input wire logic                          fine_tune_en,
  input wire logic                          tune_busy,
  input wire logic                          retune_needed
);
  // ****************************************
  // properties, mclk domain
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  property p_ua; pump_current_ua == (11'(pump_current_sel) + 11'h001) * 11'h0c8; endproperty
  a_ua: assert property (p_ua) else $error("pump current");
  property p_fixed; pump_delay_sel == 2'h0 && !detector_polarity; endproperty
  a_fixed: assert property (p_fixed) else $error("fixed field");
  property p_highz; pump_high_z == $past(operation_mode[6]); endproperty
  a_highz: assert property (p_highz) else $error("pump high z");
  property p_ratio; prescaler_ratio_sel == $past(operation_mode[21]); endproperty
  a_ratio: assert property (p_ratio) else $error("prescaler ratio");
  property p_unused;
    (operation_mode[15:13] inside {[3'h3:3'h6]})[*3] |-> diag_code_unused && !lock_indicator_pin;
  endproperty
  a_unused: assert property (p_unused) else $error("unused code");
  property p_one_hold;
    $onehot0({$changed(operation_mode), $changed(auto_calibration_control),
              $changed(frequency_control_one), $changed(frequency_control_two)});
  endproperty
  a_one_hold: assert property (p_one_hold) else $error("two holds");
  property p_start;
    $rose(auto_calibration_control[18]) |-> ##[2:4] tune_busy && coarse_cap == 7'h40;
  endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_search;
    $rose(tune_busy) |-> ##[130:160] $fell(tune_busy) ##[0:2] fine_tune_en;
  endproperty
  a_search: assert property (p_search) else $error("search length");
  property p_busy_fine; tune_busy |-> !fine_tune_en; endproperty
  a_busy_fine: assert property (p_busy_fine) else $error("fine in search");
  property p_retune;
    $changed(frequency_control_one) || $changed(frequency_control_two) |-> ##[0:2] retune_needed;
  endproperty
  a_retune: assert property (p_retune) else $error("retune flag");
endmodule : sscb_checker

bind sscb_top sscb_checker u_chk (
  .mclk(mclk), .rstn(rstn), .operation_mode(operation_mode),
  .auto_calibration_control(auto_calibration_control),
  .frequency_control_one(frequency_control_one), .frequency_control_two(frequency_control_two),
  .pump_current_sel(pump_current_sel), .pump_current_ua(pump_current_ua),
  .pump_delay_sel(pump_delay_sel), .detector_polarity(detector_polarity),
  .pump_high_z(pump_high_z), .prescaler_ratio_sel(prescaler_ratio_sel),
  .lock_indicator_pin(lock_indicator_pin), .diag_code_unused(diag_code_unused),
  .coarse_cap(coarse_cap), .fine_tune_en(fine_tune_en), .tune_busy(tune_busy),
  .retune_needed(retune_needed)
);

// file: tb/sscb_host_model.sv
// host side of the three-wire link
`timescale 1ns/10ps
module sscb_host_model
  import sscb_pkg::*;
(
  output logic sclk,
  output logic sdata,
  output logic latch_strobe
);
  // serial clock stands still between frames
  initial begin
    sclk = 1'b0;
    sdata = 1'b0;
    latch_strobe = 1'b0;
  end

  task automatic send_word(input logic [sscb_pkg::WORD_W-1:0] w);
    // odd lead-in, off the mclk grid
    #(173);
    for (int i = WORD_W - 1; i >= 0; i--) begin
      sdata = w[i];
      #(62.5) sclk = 1'b1;
      #(62.5) sclk = 1'b0;
    end
    // released line shows inverse
    sdata = ~w[0];
    #(40) latch_strobe = 1'b1;
    #(200) latch_strobe = 1'b0;
  endtask : send_word
endmodule : sscb_host_model

// file: tb/test_synth_serial_config_bank.sv
// bench for the configuration bank
`timescale 1ns/10ps
module test_synth_serial_config_bank;
  import sscb_pkg::*;
  localparam logic [6:0] TARGET = 7'h5a;
  logic                mclk, rstn, vco_above, sclk, sdata, latch_strobe;
  logic [3:0]          src;
  logic [HOLD_W-1:0]   operation_mode, auto_calibration_control;
  logic [HOLD_W-1:0]   frequency_control_one, frequency_control_two;
  logic [2:0]          pump_current_sel;
  logic [10:0]         pump_current_ua;
  logic [1:0]          pump_delay_sel, ref_buffer_bandwidth, prescaler_bias_sel;
  logic                detector_polarity, pump_high_z, modulator_supply_ctrl;
  logic                divider_supply_ctrl, pll_supply_ctrl, prescaler_ratio_sel;
  logic                lock_indicator_pin, diag_code_unused, fine_tune_en;
  logic                tune_busy, retune_needed;
  logic [CAP_W-1:0]    coarse_cap;
  int                  mismatches = 0;
  int                  checks = 0;

  sscb_host_model host (.sclk(sclk), .sdata(sdata), .latch_strobe(latch_strobe));
  sscb_top uut (
    .mclk(mclk), .rstn(rstn), .sclk(sclk), .sdata(sdata), .latch_strobe(latch_strobe),
    .lock_detect_in(src[0]), .ref_div_in(src[1]), .fb_div_in(src[2]),
    .dloop_test_in(src[3]), .vco_above_target(vco_above),
    .operation_mode(operation_mode), .auto_calibration_control(auto_calibration_control),
    .frequency_control_one(frequency_control_one),
    .frequency_control_two(frequency_control_two),
    .pump_current_sel(pump_current_sel), .pump_current_ua(pump_current_ua),
    .pump_delay_sel(pump_delay_sel), .detector_polarity(detector_polarity),
    .pump_high_z(pump_high_z), .modulator_supply_ctrl(modulator_supply_ctrl),
    .divider_supply_ctrl(divider_supply_ctrl), .pll_supply_ctrl(pll_supply_ctrl),
    .ref_buffer_bandwidth(ref_buffer_bandwidth), .prescaler_bias_sel(prescaler_bias_sel),
    .prescaler_ratio_sel(prescaler_ratio_sel), .lock_indicator_pin(lock_indicator_pin),
    .diag_code_unused(diag_code_unused), .coarse_cap(coarse_cap),
    .fine_tune_en(fine_tune_en), .tune_busy(tune_busy), .retune_needed(retune_needed)
  );

  // ****************************************
  // clock, reset, models, watchdog
  // ****************************************
  initial begin
    mclk = 1'b0;
    rstn = 1'b0;
    src = 4'h0;
    vco_above = 1'b0;
  end
  always #25 mclk = ~mclk;
  // above while trial code not past target
  always @(posedge mclk) vco_above <= (coarse_cap <= TARGET);
  initial begin
    #1_000_000;
    mismatches++;
    finish_test();
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick

  // hold and decode settle in 8 clocks
  task automatic commit(input logic [WORD_W-1:0] w);
    host.send_word(w);
    tick(8);
  endtask : commit

  task automatic finish_test();
    if (mismatches == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    check("op", operation_mode, 24'h0);
    check("cal", auto_calibration_control, 24'h0);
    check("f1", frequency_control_one, 24'h0);
    check("f2", frequency_control_two, 24'h0);
    check("ua", pump_current_ua, 11'h0c8);
    check("retune", retune_needed, 1'b1);
  endtask : t_reset

  task automatic t_op_fields();
    logic [WORD_W-1:0] w;
    for (int k = 0; k < 8; k++) begin
      w = {2'h0, k[1], k[2:1], 6'h0, k[1:0], k[2:0], 1'b0, {2{k[0]}}, k[1:0], k[2:0], 2'h0};
      commit(w);
      check("op", operation_mode, w[25:2]);
      check("sel", pump_current_sel, k[2:0]);
      check("ua", pump_current_ua, 32'((k + 1) * 200));
      check("dly", pump_delay_sel, 2'h0);
      check("pol", detector_polarity, 1'b0);
      check("hiz", pump_high_z, w[8]);
      check("sup", {pll_supply_ctrl,divider_supply_ctrl,modulator_supply_ctrl}, w[12:10]);
      check("bw", ref_buffer_bandwidth, w[14:13]);
      check("bias", prescaler_bias_sel, w[22:21]);
      check("ratio", prescaler_ratio_sel, w[23]);
    end
  endtask : t_op_fields

  task automatic t_lock();
    logic [2:0] code [5] = '{3'h0, 3'h1, 3'h2, 3'h7, 3'h3};
    for (int j = 0; j < 5; j++) begin
      commit({8'h0, code[j], 15'h0});
      for (int v = 0; v < 2; v++) begin
        @(posedge mclk);
        src <= (v == 0) ? 4'(1 << j) : ~4'(1 << j);
        tick(6);
        check("lock", lock_indicator_pin, (j < 4) && (v == 0));
        check("unused", diag_code_unused, j == 4);
      end
    end
  endtask : t_lock

  task automatic t_addr();
    logic [HOLD_W-1:0] exp [4];
    logic [WORD_W-1:0] w;
    exp[0] = 24'h006000; // lock scenario's last word
    for (int a = 1; a < 4; a++) begin
      w = {8'(a * 8'h33), 16'hc3a5, a[1:0]};
      exp[a] = w[25:2];
      commit(w);
    end
    check("op", operation_mode, exp[0]);
    check("cal", auto_calibration_control, exp[1]);
    check("f1", frequency_control_one, exp[2]);
    check("f2", frequency_control_two, exp[3]);
  endtask : t_addr

  task automatic t_tune();
    int n;
    commit(26'h0000001);
    commit(26'h0100001);
    check("busy", tune_busy, 1'b1);
    n = 0;
    while (tune_busy === 1'b1 && n < 300) begin
      tick(1);
      n++;
    end
    tick(2);
    check("cap", coarse_cap, TARGET);
    check("fine", fine_tune_en, 1'b1);
    check("retune", retune_needed, 1'b0);
    commit(26'h2abcde);
    check("retune", retune_needed, 1'b1);
    check("fine", fine_tune_en, 1'b0);
    // one again is no edge
    commit(26'h0100001);
    tick(10);
    check("busy", tune_busy, 1'b0);
  endtask : t_tune

  initial begin
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    tick(2);
    t_reset();
    t_op_fields();
    t_lock();
    t_addr();
    t_tune();
    finish_test();
  end
endmodule : test_synth_serial_config_bank
